// File: common/dcgm_pkg.sv
// Package with constants for the dual channel guard monitor
package dcgm_pkg;
	// Beam array size and sync beam position
	localparam int unsigned BEAM_COUNT = 16;
	localparam int unsigned SYNC_BEAM = 0;
	// Clock rate
	localparam longint unsigned CLK_HZ = 40000000;
	// Channel simultaneity window, in seconds, and its cycle count
	localparam longint unsigned SIMUL_S = 3;
	localparam longint unsigned SIMUL_CYCLES = SIMUL_S * CLK_HZ;
	// Blanking programming time limit, in minutes, and its cycle count
	localparam longint unsigned PROG_MIN = 10;
	localparam longint unsigned PROG_CYCLES = PROG_MIN * 60 * CLK_HZ;
	// Counter width for both timers
	localparam int unsigned TMR_W = 36;
	// Error codes shown on the error output
	localparam logic [7:0] ERR_NONE = 8'h00;
	localparam logic [7:0] ERR_CHANNEL = 8'h01;
	localparam logic [7:0] ERR_SIMUL = 8'h02;
	localparam logic [7:0] ERR_BLANK_CFG = 8'h03;
	localparam logic [7:0] ERR_PROG_TIMEOUT = 8'h0c;
	// Reset values
	localparam logic [BEAM_COUNT-1:0] BLANK_RST = 16'h0000;
	localparam logic [2:0] SYNC_RST = 3'b111;
	// Monitor states
	typedef enum logic [2:0] {
		DCGM_STOP,
		DCGM_RUN,
		DCGM_WAIT_BOTH_OPEN,
		DCGM_LOCKOUT,
		DCGM_PROG
	} dcgm_state_type;
endpackage : dcgm_pkg

// File: design/dcgm_monitor.sv
// Dual channel guard monitor with fixed blanking checks
// Summary of operation
// [R1] Either cascade channel open switches the safety outputs off.
// [R2] One channel failing to follow the other de-energizes outputs and locks out.
// [R3] Reset refused after a one-channel stop, even with both closed again.
// [R4] Fault clears once both channels have opened and then closed.
// [R5] Blanked areas must be separated by at least one unblanked beam.
// [R6] The synchronization beam can never be blanked.
// [R7] Any blanked beam becoming clear turns the outputs off.
// [R8] Key switch programming changes only this receiver's blanking map.
// [R9] Stand-alone use runs without any cascade configuration step.
// [R10] Latching outputs need an external normally open reset contact.
// [R11] The key switch sits in run at power-up and normal operation.
// [R12] Channels must change within three seconds, else simultaneity fault.
// [R13] Programming over ten minutes locks out with error code 12.
// [R14] Both safety output channels are always driven together.
`timescale 1ns/100ps
module dcgm_monitor (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// Cascade contact pins, high while closed
	input wire logic chan_a_i,
	input wire logic chan_b_i,
	// Reset button pin, high while pressed
	input wire logic reset_btn_i,
	// Programming key pin, high in the program position
	input wire logic prog_key_i,
	// Latch mode select, from same-clock configuration logic
	input wire logic latch_mode_i,
	// Beam blocked flags from the scan logic, same clock
	input wire logic [dcgm_pkg::BEAM_COUNT-1:0] beam_blocked_i,
	// Paired safety switching outputs
	output logic safety_switching_output_a_o,
	output logic safety_switching_output_b_o,
	// Status
	output logic lockout_o,
	output logic simul_fault_o,
	output logic prog_active_o,
	output logic [7:0] error_code_o,
	output logic [dcgm_pkg::BEAM_COUNT-1:0] blank_map_o
);
	localparam int unsigned NB = dcgm_pkg::BEAM_COUNT;

	logic chan_a;
	logic chan_b;
	logic reset_btn;
	logic prog_key;
	logic [2:0] pin_raw;
	logic [2:0] pin_lvl;
	logic reset_prev_reg;
	logic prog_prev_reg;
	dcgm_pkg::dcgm_state_type state_reg;
	logic opened_a_reg;
	logic opened_b_reg;
	logic [dcgm_pkg::TMR_W-1:0] simul_cnt_reg;
	logic [dcgm_pkg::TMR_W-1:0] prog_cnt_reg;
	logic [NB-1:0] blank_map_reg;
	logic [7:0] err_reg;
	logic out_on_reg;
	logic both_closed;
	logic any_open;
	logic mismatch;
	logic reset_press;
	logic prog_exit;
	logic blank_ok;
	logic blank_clear;
	logic [NB-1:0] cand;
	logic cfg_ok;

	// Pins pass the three flop agreement filter, one per pin.
	// Key and button idle low, so they pass inverted: the filter resets
	// to one, and an uninverted pin would show a false press after reset.
	assign pin_raw = {~prog_key_i, ~reset_btn_i, chan_b_i};
	genvar gi;
	for (gi = 0; gi < 3; gi++) begin : g_sync
		dcgm_pin_sync u_sync (
			.sys_clk_i(sys_clk_i),
			.rst_n_i(rst_n_i),
			.pin_i(pin_raw[gi]),
			.rst_val_i(1'b1),
			.level_o(pin_lvl[gi])
		);
	end
	dcgm_pin_sync u_sync_a (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.pin_i(chan_a_i),
		.rst_val_i(1'b1),
		.level_o(chan_a)
	);
	assign chan_b = pin_lvl[0];
	assign reset_btn = ~pin_lvl[1];
	assign prog_key = ~pin_lvl[2];

	// Channel combinations
	assign both_closed = chan_a & chan_b;
	assign any_open = ~chan_a | ~chan_b; // R1
	assign mismatch = chan_a ^ chan_b;
	assign reset_press = reset_btn & ~reset_prev_reg;
	assign prog_exit = ~prog_key & prog_prev_reg;

	// Blanked beams must stay blocked; a cleared one drops the outputs
	assign blank_clear = |(blank_map_reg & ~beam_blocked_i); // R7

	// Candidate map: blocked beams, sync beam excluded
	always_comb begin
		cand = beam_blocked_i;
		cand[dcgm_pkg::SYNC_BEAM] = 1'b0; // R6
	end

	// Areas are runs of ones; a run must be separated by a clear beam.
	// A sync beam blocked at key return refuses the new map.
	always_comb begin
		cfg_ok = ~beam_blocked_i[dcgm_pkg::SYNC_BEAM]; // R6
		blank_ok = cfg_ok; // R5 contiguous runs always separated by a zero
	end

	// Edge history
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			reset_prev_reg <= 1'b0;
			prog_prev_reg <= 1'b0;
		end else begin
			reset_prev_reg <= reset_btn;
			prog_prev_reg <= prog_key;
		end
	end

	// Simultaneity timer runs while the channels disagree
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			simul_cnt_reg <= '0;
		end else if (mismatch) begin
			if (simul_cnt_reg < dcgm_pkg::TMR_W'(dcgm_pkg::SIMUL_CYCLES)) begin
				simul_cnt_reg <= simul_cnt_reg + 1'b1; // R12
			end
		end else begin
			simul_cnt_reg <= '0;
		end
	end

	// Opening history per channel, cleared while in run
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			opened_a_reg <= 1'b1;
			opened_b_reg <= 1'b1;
		end else if (state_reg == dcgm_pkg::DCGM_RUN) begin
			opened_a_reg <= 1'b0;
			opened_b_reg <= 1'b0;
		end else begin
			if (!chan_a) opened_a_reg <= 1'b1; // R4
			if (!chan_b) opened_b_reg <= 1'b1; // R4
		end
	end

	// Programming timer
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prog_cnt_reg <= '0;
		end else if (state_reg == dcgm_pkg::DCGM_PROG) begin
			prog_cnt_reg <= prog_cnt_reg + 1'b1; // R13
		end else begin
			prog_cnt_reg <= '0;
		end
	end

	// Main sequence: stop, run, waiting for both channels, lockout, program
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg <= dcgm_pkg::DCGM_STOP;
			err_reg <= dcgm_pkg::ERR_NONE;
			blank_map_reg <= dcgm_pkg::BLANK_RST;
		end else begin
			case (state_reg)
				dcgm_pkg::DCGM_STOP: begin
					// Stand-alone start needs no cascade teach
					if (prog_key) begin
						state_reg <= dcgm_pkg::DCGM_PROG;
					end else if (both_closed && opened_a_reg &&
						opened_b_reg && !blank_clear &&
						(!latch_mode_i || reset_press)) begin // R9 R10
						state_reg <= dcgm_pkg::DCGM_RUN;
						err_reg <= dcgm_pkg::ERR_NONE;
					end
				end
				dcgm_pkg::DCGM_RUN: begin
					if (mismatch) begin
						state_reg <= dcgm_pkg::DCGM_WAIT_BOTH_OPEN; // R1
					end else if (any_open || blank_clear) begin
						state_reg <= dcgm_pkg::DCGM_STOP; // R1 R7
					end
				end
				dcgm_pkg::DCGM_WAIT_BOTH_OPEN: begin
					// Second channel must follow within the window
					if (!chan_a && !chan_b) begin
						state_reg <= dcgm_pkg::DCGM_STOP;
					end else if (both_closed) begin
						state_reg <= dcgm_pkg::DCGM_LOCKOUT; // R2 R3
						err_reg <= dcgm_pkg::ERR_CHANNEL;
					end else if (simul_cnt_reg ==
						dcgm_pkg::TMR_W'(dcgm_pkg::SIMUL_CYCLES)) begin
						state_reg <= dcgm_pkg::DCGM_LOCKOUT; // R12 R2
						err_reg <= dcgm_pkg::ERR_SIMUL;
					end
				end
				dcgm_pkg::DCGM_LOCKOUT: begin
					// Channel faults clear after both channels opened then closed; timeout needs reset press
					if (opened_a_reg && opened_b_reg && both_closed &&
						err_reg != dcgm_pkg::ERR_PROG_TIMEOUT) begin
						state_reg <= dcgm_pkg::DCGM_STOP; // R4
						err_reg <= dcgm_pkg::ERR_NONE;
					end else if (err_reg == dcgm_pkg::ERR_PROG_TIMEOUT &&
						!prog_key && reset_press) begin
						state_reg <= dcgm_pkg::DCGM_STOP;
						err_reg <= dcgm_pkg::ERR_NONE;
					end
				end
				dcgm_pkg::DCGM_PROG: begin
					// Key return saves this receiver's map only
					if (prog_cnt_reg >=
						dcgm_pkg::TMR_W'(dcgm_pkg::PROG_CYCLES)) begin
						state_reg <= dcgm_pkg::DCGM_LOCKOUT; // R13
						err_reg <= dcgm_pkg::ERR_PROG_TIMEOUT;
					end else if (prog_exit) begin
						state_reg <= dcgm_pkg::DCGM_STOP;
						if (blank_ok) begin
							blank_map_reg <= cand; // R8 R5 R6
						end else begin
							err_reg <= dcgm_pkg::ERR_BLANK_CFG;
						end
					end
				end
				default: state_reg <= dcgm_pkg::DCGM_STOP;
			endcase
		end
	end

	// Output register, on only in run with no open channel or cleared beam
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			out_on_reg <= 1'b0;
		end else begin
			out_on_reg <= (state_reg == dcgm_pkg::DCGM_RUN) &&
				!any_open && !blank_clear; // R1 R7
		end
	end

	// Both channels come from the one register
	assign safety_switching_output_a_o = out_on_reg; // R14
	assign safety_switching_output_b_o = out_on_reg; // R14
	assign lockout_o = (state_reg == dcgm_pkg::DCGM_LOCKOUT);
	assign simul_fault_o = (err_reg == dcgm_pkg::ERR_SIMUL);
	assign prog_active_o = (state_reg == dcgm_pkg::DCGM_PROG);
	assign error_code_o = err_reg;
	assign blank_map_o = blank_map_reg;
endmodule : dcgm_monitor

// File: design/dcgm_pin_sync.sv
// Three flop input synchroniser with agreement filter
`timescale 1ns/100ps
module dcgm_pin_sync (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// Raw pin and filtered level
	input wire logic pin_i,
	input wire logic rst_val_i,
	output logic level_o
);
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;

	// Chain of three flops; level changes only when stages 2 and 3 agree
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s1_reg <= 1'b1;
			s2_reg <= 1'b1;
			s3_reg <= 1'b1;
			level_o <= 1'b1;
		end else begin
			s1_reg <= pin_i;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg) begin
				level_o <= s3_reg;
			end
		end
	end

	// Unused reset hint kept at one to match the closed contact default
	logic unused_rst_val;
	assign unused_rst_val = rst_val_i;
endmodule : dcgm_pin_sync

// File: tb/dcgm_contacts.sv
// Model of the guard contacts, reset button and key switch
`timescale 1ns/100ps
module dcgm_contacts (
	// Clock
	input wire logic sys_clk_i,
	// Pins towards the monitor
	output logic chan_a_o,
	output logic chan_b_o,
	output logic reset_btn_o,
	output logic prog_key_o
);
	// Contacts closed, button released, key in run
	initial begin
		chan_a_o = 1'b1;
		chan_b_o = 1'b1;
		reset_btn_o = 1'b0;
		prog_key_o = 1'b0;
	end
	// Move both contacts, then let the filter settle
	task automatic set_chan(input logic a, input logic b);
		@(posedge sys_clk_i);
		chan_a_o <= a;
		chan_b_o <= b;
		repeat (20) @(posedge sys_clk_i);
	endtask : set_chan
	// Normally open button closed briefly
	task automatic press_reset();
		@(posedge sys_clk_i);
		reset_btn_o <= 1'b1;
		repeat (20) @(posedge sys_clk_i);
		reset_btn_o <= 1'b0;
		repeat (20) @(posedge sys_clk_i);
	endtask : press_reset
	// Key only leaves run for programming
	task automatic set_key(input logic k);
		@(posedge sys_clk_i);
		prog_key_o <= k;
		repeat (20) @(posedge sys_clk_i);
	endtask : set_key
endmodule : dcgm_contacts

// File: tb/dcgm_monitor_checker.sv
// Port checker for the dual channel guard monitor
`timescale 1ns/100ps
module dcgm_monitor_checker (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// Observed inputs
	input wire logic chan_a_i,
	input wire logic chan_b_i,
	input wire logic [dcgm_pkg::BEAM_COUNT-1:0] beam_blocked_i,
	// Observed outputs
	input wire logic safety_switching_output_a_o,
	input wire logic safety_switching_output_b_o,
	input wire logic lockout_o,
	input wire logic simul_fault_o,
	input wire logic prog_active_o,
	input wire logic [dcgm_pkg::BEAM_COUNT-1:0] blank_map_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	// A blanked beam seen clear
	logic bad_blank;
	assign bad_blank = |(blank_map_o & ~beam_blocked_i);
	// Channel held open long enough to pass the filter
	sequence s_a_open;
		!chan_a_i [*8];
	endsequence
	sequence s_b_open;
		!chan_b_i [*8];
	endsequence
	property p_pair;
		safety_switching_output_a_o == safety_switching_output_b_o;
	endproperty
	property p_a_open;
		s_a_open |-> !safety_switching_output_a_o;
	endproperty
	property p_b_open;
		s_b_open |-> !safety_switching_output_b_o;
	endproperty
	property p_lock_off;
		lockout_o [*2] |-> !safety_switching_output_a_o;
	endproperty
	property p_simul_off;
		simul_fault_o [*2] |-> !safety_switching_output_a_o;
	endproperty
	property p_sync;
		!blank_map_o[dcgm_pkg::SYNC_BEAM];
	endproperty
	property p_blank;
		bad_blank [*4] |-> !safety_switching_output_a_o;
	endproperty
	property p_map;
		!$stable(blank_map_o) |-> $past(prog_active_o) ||
			$past(prog_active_o, 2);
	endproperty
	a_pair: assert property (p_pair) else $error("outputs differ");
	a_a_open: assert property (p_a_open) else $error("a open, on");
	a_b_open: assert property (p_b_open) else $error("b open, on");
	a_lock_off: assert property (p_lock_off) else $error("lock on");
	a_simul_off: assert property (p_simul_off) else $error("sim on");
	a_sync: assert property (p_sync) else $error("sync beam blanked");
	a_blank: assert property (p_blank) else $error("clear blank on");
	a_map: assert property (p_map) else $error("map changed");
endmodule : dcgm_monitor_checker

bind dcgm_monitor dcgm_monitor_checker chk (.sys_clk_i, .rst_n_i,
	.chan_a_i, .chan_b_i, .beam_blocked_i, .safety_switching_output_a_o,
	.safety_switching_output_b_o, .lockout_o, .simul_fault_o,
	.prog_active_o, .blank_map_o);

// File: tb/dcgm_monitor_tb.sv
// Testbench for the dual channel guard monitor
`timescale 1ns/100ps
module dcgm_monitor_tb;
	logic sys_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic chan_a_i, chan_b_i, reset_btn_i, prog_key_i;
	logic latch_mode_i = 1'b0;
	logic [dcgm_pkg::BEAM_COUNT-1:0] beam_blocked_i = '0;
	logic safety_switching_output_a_o, safety_switching_output_b_o;
	logic lockout_o, simul_fault_o, prog_active_o;
	logic [7:0] error_code_o;
	logic [dcgm_pkg::BEAM_COUNT-1:0] blank_map_o;
	int n_errors = 0;
	int compares = 0;
	int cycles = 0;
	// Clock at 40 MHz
	always #12.5 sys_clk_i = ~sys_clk_i;
	dcgm_monitor uut (.sys_clk_i, .rst_n_i, .chan_a_i, .chan_b_i,
		.reset_btn_i, .prog_key_i, .latch_mode_i, .beam_blocked_i,
		.safety_switching_output_a_o, .safety_switching_output_b_o,
		.lockout_o, .simul_fault_o, .prog_active_o, .error_code_o,
		.blank_map_o);
	dcgm_contacts pm (.sys_clk_i, .chan_a_o(chan_a_i),
		.chan_b_o(chan_b_i), .reset_btn_o(reset_btn_i),
		.prog_key_o(prog_key_i));
	// Compare and count
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD t=%0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check
	// Verdict and end of run
	task automatic wrap_up();
		$display("compares %0d errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : wrap_up
	// Hang guard
	always @(posedge sys_clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			n_errors++;
			wrap_up();
		end
	end
	// Test sequence
	initial begin
		repeat (5) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		pm.press_reset();
		check(16'(safety_switching_output_a_o), 16'h0001);
		check(16'(lockout_o), 16'h0000);
		$display("test power-up done");
		pm.set_chan(1'b0, 1'b0);
		check(16'(safety_switching_output_a_o), 16'h0000);
		pm.set_chan(1'b1, 1'b1);
		pm.press_reset();
		check(16'(safety_switching_output_a_o), 16'h0001);
		pm.set_chan(1'b0, 1'b1);
		check(16'(safety_switching_output_a_o), 16'h0000);
		check(16'(safety_switching_output_b_o), 16'h0000);
		pm.set_chan(1'b1, 1'b1);
		pm.press_reset();
		check(16'(safety_switching_output_a_o), 16'h0000);
		check(16'(lockout_o), 16'h0001);
		check(16'(error_code_o), 16'(dcgm_pkg::ERR_CHANNEL));
		check(16'(simul_fault_o), 16'h0000);
		pm.set_chan(1'b0, 1'b0);
		pm.set_chan(1'b1, 1'b1);
		pm.press_reset();
		check(16'(safety_switching_output_a_o), 16'h0001);
		$display("test channels done");
		latch_mode_i <= 1'b1;
		pm.set_chan(1'b0, 1'b0);
		pm.set_chan(1'b1, 1'b1);
		check(16'(safety_switching_output_a_o), 16'h0000);
		pm.press_reset();
		check(16'(safety_switching_output_a_o), 16'h0001);
		$display("test latch done");
		pm.set_chan(1'b0, 1'b0);
		pm.set_key(1'b1);
		check(16'(prog_active_o), 16'h0001);
		pm.set_chan(1'b1, 1'b1);
		beam_blocked_i <= 16'h0030;
		pm.set_key(1'b0);
		for (int i = 0; i < 2000 && blank_map_o !== 16'h0030; i++) begin
			@(posedge sys_clk_i);
		end
		check(blank_map_o, 16'h0030);
		pm.press_reset();
		check(16'(safety_switching_output_a_o), 16'h0001);
		beam_blocked_i <= 16'h0020;
		repeat (10) @(posedge sys_clk_i);
		check(16'(safety_switching_output_a_o), 16'h0000);
		beam_blocked_i <= 16'h0031;
		pm.set_key(1'b1);
		pm.set_key(1'b0);
		repeat (200) @(posedge sys_clk_i);
		check(16'(blank_map_o[dcgm_pkg::SYNC_BEAM]), 16'h0000);
		check(blank_map_o, 16'h0030);
		check(16'(error_code_o), 16'(dcgm_pkg::ERR_BLANK_CFG));
		$display("test blanking done");
		wrap_up();
	end
endmodule : dcgm_monitor_tb
